// ### scp_pkg.sv
// Constants, field layouts and state types of the serial control port
package scp_pkg;

   // Control word layout: 7 address bits over 9 data bits
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned REG_ADDR_W  = 7;
   localparam int unsigned REG_DATA_W  = 9;
   localparam int unsigned WORD_ADDR_LSB = 9;
   localparam int unsigned BYTE_W      = 8;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;

   // Fixed bus address of the 2-wire slave
   localparam logic [6:0]  DEV_ADDR    = 7'h1A;

   // Register offsets
   localparam logic [6:0]  OFF_SOFT_RESET = 7'h00;
   localparam logic [6:0]  OFF_POWER_ONE  = 7'h01;
   localparam logic [6:0]  OFF_PIN_FUNC   = 7'h08;
   localparam logic [6:0]  OFF_CONVERTER  = 7'h0E;

   // Reset values
   localparam logic [8:0]  POWER_ONE_RST  = 9'h000;
   localparam logic [8:0]  PIN_FUNC_RST   = 9'h000;
   localparam logic [8:0]  CONVERTER_RST  = 9'h100;

   // Field positions
   localparam int unsigned SEL_LSB   = 0;
   localparam int unsigned POL_BIT   = 3;
   localparam int unsigned DIV_LSB   = 4;
   localparam int unsigned OSR_BIT   = 3;
   localparam int unsigned MID_LSB   = 0;
   localparam int unsigned BIAS_BIT  = 3;
   localparam int unsigned PLLEN_BIT = 5;

   // Pin function select codes
   localparam logic [2:0]  SEL_CHIP_SELECT = 3'h0;
   localparam logic [2:0]  SEL_TEMP_OK     = 3'h2;
   localparam logic [2:0]  SEL_AUTO_MUTE   = 3'h3;
   localparam logic [2:0]  SEL_PLL_CLOCK   = 3'h4;
   localparam logic [2:0]  SEL_PLL_LOCK    = 3'h5;

   // 2-wire transfer states
   typedef enum logic [2:0] {
      SCP_TW_IDLE,
      SCP_TW_ADDR,
      SCP_TW_ACK_ADDR,
      SCP_TW_BYTE_HI,
      SCP_TW_ACK_HI,
      SCP_TW_BYTE_LO,
      SCP_TW_ACK_LO,
      SCP_TW_DONE
   } scp_tw_state_t;

   // Control registers as seen by the rest of the chip
   typedef struct packed {
      logic [8:0] power_control_one;
      logic [8:0] pin_function_control;
      logic [8:0] converter_control;
   } scp_regs_t;

   // Two-flop synchronisers plus previous value for edge detection
   typedef struct packed {
      logic s1;
      logic s2;
      logic d;
   } scp_sync_t;

   // Whole state of the control port
   typedef struct packed {
      scp_sync_t     scl;
      scp_sync_t     sda;
      scp_sync_t     cs;
      scp_sync_t     pclk;
      scp_sync_t     mode;
      scp_sync_t     temp;
      scp_sync_t     amute;
      scp_sync_t     lock;
      logic [15:0]   shift3;
      scp_tw_state_t tw;
      logic [3:0]    bit_cnt;
      logic [7:0]    shift8;
      logic [15:0]   word;
      logic          sda_oe;
      scp_regs_t     regs;
      logic [1:0]    div_cnt;
      logic          div_out;
      logic          pin_out;
      logic          pin_oe;
   } scp_state_t;

endpackage

// ### scp_control_port.sv
// Serial control port: 3-wire and 2-wire register writes, pin mux and control registers
//
// How it works
// - Pin function chosen by 3-bit select; polarity bit inverts the driven value.
// - Pin drives outputs only in 2-wire mode; in 3-wire it is chip select.
// - PLL clock on pin divided by 1 to 4 from field bits 5:4.
// - Mode pin low selects 2-wire, high selects 3-wire operation.
// - Control word is 16 bits: address in 15:9, data in 8:0.
// - In 3-wire mode one data bit is shifted per serial clock rising edge.
// - Chip select rising edge commits the last 16 shifted bits.
// - Data falling while clock high is a start condition.
// - After start, eight bits MSB first: device address then read/write bit.
// - Matching address is acknowledged by holding data low one clock pulse.
// - Wrong address or read request returns to idle without acknowledge.
// - Two data bytes follow, high then low, each acknowledged.
// - Data rising while clock high ends the transfer and completes the write.
// - Start or stop out of sequence abandons the transfer to idle.
// - 2-wire slave answers only bus address 0011010.
// - Any write to register address 0 restores all register defaults.
// - Power-on reset loads default values into all registers.
// - Oversampling bit 3 selects 64x when clear, 128x when set.
// - Midrail field selects off, 75k, 300k, 2.5k; off keeps analogue inoperative.
// - Bit 3 of power register one enables amplifier bias, clear by default.
`timescale 1ns/1ps
`default_nettype none

module scp_control_port (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             mode_pin,
   input  wire logic             serial_clock,
   input  wire logic             serial_data_line_in,
   output logic                  serial_data_line_out,
   output logic                  serial_data_line_oe,
   input  wire logic             select_or_io_pin_in,
   output logic                  select_or_io_pin_out,
   output logic                  select_or_io_pin_oe,
   input  wire logic             pll_clock,
   input  wire logic             pll_lock,
   input  wire logic             temp_ok,
   input  wire logic             auto_mute_active,
   output scp_pkg::scp_regs_t    regs,
   output logic                  three_wire_mode,
   output logic                  oversample_double,
   output logic [1:0]            midrail_impedance_select,
   output logic                  analogue_enabled,
   output logic                  amp_bias_enable,
   output logic                  pll_enable
);

   // All state lives in one packed struct: the block below builds the
   // next copy and a single flop bank registers it, so every state bit
   // has exactly one driver and one reset value.
   scp_pkg::scp_state_t st_reg;
   scp_pkg::scp_state_t st_next;

   // Decoded views of the registered state
   // All combinational, and all read only registered values
   logic       scl_rise;
   logic       scl_fall;
   logic       sda_rise;
   logic       sda_fall;
   logic       cs_rise;
   logic       pclk_edge;
   logic       start_seen;
   logic       stop_seen;
   logic       in_three_wire;
   logic [2:0] pin_sel;
   logic [1:0] div_sel;
   logic       pin_val;
   logic       pin_drive;

   // Edge detects look only at the second flop and its delayed copy
   // The first flop may still be settling, so nothing else reads it
   // A pin edge is therefore seen three mclk cycles after it happens
   assign scl_rise  = st_reg.scl.s2 & ~st_reg.scl.d;
   assign scl_fall  = ~st_reg.scl.s2 & st_reg.scl.d;
   assign sda_rise  = st_reg.sda.s2 & ~st_reg.sda.d;
   assign sda_fall  = ~st_reg.sda.s2 & st_reg.sda.d;
   assign cs_rise   = st_reg.cs.s2 & ~st_reg.cs.d;
   assign pclk_edge = st_reg.pclk.s2 ^ st_reg.pclk.d;

   // A data edge while the clock is high is a start or a stop
   // Host must keep data steady four cycles around clock edges
   // Both clock samples high so a data edge racing the clock edge is not taken
   assign start_seen = sda_fall & st_reg.scl.s2 & st_reg.scl.d;
   assign stop_seen  = sda_rise & st_reg.scl.s2 & st_reg.scl.d;

   // Mode is a level; switching it parks the 2-wire machine at once
   assign in_three_wire = st_reg.mode.s2;

   // Function and divider fields of the pin register
   assign pin_sel = st_reg.regs.pin_function_control[scp_pkg::SEL_LSB +: 3];
   assign div_sel = st_reg.regs.pin_function_control[scp_pkg::DIV_LSB +: 2];

   // Pin mux source; reserved codes and chip-select code leave the pin undriven
   // Polarity is applied where the pin value is registered
   always_comb begin
      pin_val   = 1'b0;
      pin_drive = 1'b1;
      case (pin_sel)
         scp_pkg::SEL_TEMP_OK:   pin_val = st_reg.temp.s2;
         scp_pkg::SEL_AUTO_MUTE: pin_val = st_reg.amute.s2;
         scp_pkg::SEL_PLL_CLOCK: pin_val = st_reg.div_out;
         scp_pkg::SEL_PLL_LOCK:  pin_val = st_reg.lock.s2;
         default:                pin_drive = 1'b0;
      endcase
   end

   // 2-wire write, one word per transfer:
   //    start, address byte, ack, high byte, ack, low byte, ack, stop
   // Bits shift on the clock rise and a byte is judged on the eighth
   // fall, so the ack pull starts while the clock is low and lasts
   // through the whole ninth pulse. The word is written only on the
   // stop after the third ack; a cut transfer writes nothing. Start
   // and stop are ignored while we pull the line, since our own pull
   // would otherwise look like a start.
   // Next-state logic for the whole port
   always_comb begin
      logic        commit;
      logic [15:0] cword;
      logic [6:0]  caddr;
      logic [8:0]  cdata;
      logic [1:0]  div_last;

      commit   = 1'b0;
      cword    = 16'h0000;
      caddr    = 7'h00;
      cdata    = 9'h000;
      div_last = 2'h0;
      st_next  = st_reg;

      // Synchronisers for every pin and foreign-clock input
      // Last field keeps the previous second-flop value for edges
      st_next.scl   = '{s1: serial_clock,        s2: st_reg.scl.s1,   d: st_reg.scl.s2};
      st_next.sda   = '{s1: serial_data_line_in, s2: st_reg.sda.s1,   d: st_reg.sda.s2};
      st_next.cs    = '{s1: select_or_io_pin_in, s2: st_reg.cs.s1,    d: st_reg.cs.s2};
      st_next.pclk  = '{s1: pll_clock,           s2: st_reg.pclk.s1,  d: st_reg.pclk.s2};
      st_next.mode  = '{s1: mode_pin,            s2: st_reg.mode.s1,  d: st_reg.mode.s2};
      st_next.temp  = '{s1: temp_ok,             s2: st_reg.temp.s1,  d: st_reg.temp.s2};
      st_next.amute = '{s1: auto_mute_active,    s2: st_reg.amute.s1, d: st_reg.amute.s2};
      st_next.lock  = '{s1: pll_lock,            s2: st_reg.lock.s1,  d: st_reg.lock.s2};

      if (in_three_wire) begin
         // 3-wire: shift on clock rise, latch on chip-select rise
         // Shifting never stops; only the last 16 bits count at commit
         st_next.tw     = scp_pkg::SCP_TW_IDLE;
         st_next.sda_oe = 1'b0;
         if (scl_rise) begin
            st_next.shift3 = {st_reg.shift3[14:0], st_reg.sda.s2};
         end
         if (cs_rise) begin
            commit = 1'b1;
            cword  = st_reg.shift3;
         end
      end else if (start_seen && !st_reg.sda_oe) begin
         // A start begins a transfer only from idle; elsewhere it aborts
         // Counter cleared so the address byte starts at its top bit
         st_next.sda_oe  = 1'b0;
         st_next.bit_cnt = 4'h0;
         if (st_reg.tw == scp_pkg::SCP_TW_IDLE) begin
            st_next.tw = scp_pkg::SCP_TW_ADDR;
         end else begin
            st_next.tw = scp_pkg::SCP_TW_IDLE;
         end
      end else if (stop_seen && !st_reg.sda_oe) begin
         // Stop completes only a fully acknowledged word
         // In any other state the partial word is dropped
         st_next.tw     = scp_pkg::SCP_TW_IDLE;
         st_next.sda_oe = 1'b0;
         if (st_reg.tw == scp_pkg::SCP_TW_DONE) begin
            commit = 1'b1;
            cword  = st_reg.word;
         end
      end else begin
         case (st_reg.tw)
            scp_pkg::SCP_TW_IDLE: begin
               // Line released; waiting for a start
               st_next.sda_oe = 1'b0;
            end
            scp_pkg::SCP_TW_ADDR,
            scp_pkg::SCP_TW_BYTE_HI,
            scp_pkg::SCP_TW_BYTE_LO: begin
               // Shift MSB first on rise, judge the byte on the eighth fall
               if (scl_rise && st_reg.bit_cnt < scp_pkg::BYTE_BITS) begin
                  st_next.shift8  = {st_reg.shift8[6:0], st_reg.sda.s2};
                  st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               end else if (scl_fall && st_reg.bit_cnt == scp_pkg::BYTE_BITS) begin
                  st_next.bit_cnt = 4'h0;
                  if (st_reg.tw == scp_pkg::SCP_TW_ADDR) begin
                     // Address match with write bit clear, else drop silently
                     if (st_reg.shift8 == {scp_pkg::DEV_ADDR, 1'b0}) begin
                        st_next.tw     = scp_pkg::SCP_TW_ACK_ADDR;
                        st_next.sda_oe = 1'b1;
                     end else begin
                        st_next.tw = scp_pkg::SCP_TW_IDLE;
                     end
                  end else if (st_reg.tw == scp_pkg::SCP_TW_BYTE_HI) begin
                     st_next.word[15:8] = st_reg.shift8;
                     st_next.tw         = scp_pkg::SCP_TW_ACK_HI;
                     st_next.sda_oe     = 1'b1;
                  end else begin
                     st_next.word[7:0] = st_reg.shift8;
                     st_next.tw        = scp_pkg::SCP_TW_ACK_LO;
                     st_next.sda_oe    = 1'b1;
                  end
               end
            end
            scp_pkg::SCP_TW_ACK_ADDR,
            scp_pkg::SCP_TW_ACK_HI,
            scp_pkg::SCP_TW_ACK_LO: begin
               // Host samples the ack while the clock is high
               // Release after the acknowledge clock pulse has ended
               if (scl_fall) begin
                  st_next.sda_oe = 1'b0;
                  if (st_reg.tw == scp_pkg::SCP_TW_ACK_ADDR) begin
                     st_next.tw = scp_pkg::SCP_TW_BYTE_HI;
                  end else if (st_reg.tw == scp_pkg::SCP_TW_ACK_HI) begin
                     st_next.tw = scp_pkg::SCP_TW_BYTE_LO;
                  end else begin
                     st_next.tw = scp_pkg::SCP_TW_DONE;
                  end
               end
            end
            scp_pkg::SCP_TW_DONE: begin
               // Extra clocks before the stop are ignored
               // A start here aborts; only a stop commits the word
               st_next.sda_oe = 1'b0;
            end
            default: begin
               st_next.tw     = scp_pkg::SCP_TW_IDLE;
               st_next.sda_oe = 1'b0;
            end
         endcase
      end

      // Register write decode shared by both modes
      // Address in the top seven bits, data in the low nine
      // Unmapped addresses leave every register alone
      caddr = cword[scp_pkg::WORD_ADDR_LSB +: 7];
      cdata = cword[8:0];
      if (commit) begin
         case (caddr)
            scp_pkg::OFF_SOFT_RESET: begin
               st_next.regs.power_control_one    = scp_pkg::POWER_ONE_RST;
               st_next.regs.pin_function_control = scp_pkg::PIN_FUNC_RST;
               st_next.regs.converter_control    = scp_pkg::CONVERTER_RST;
            end
            scp_pkg::OFF_POWER_ONE: st_next.regs.power_control_one    = cdata;
            scp_pkg::OFF_PIN_FUNC:  st_next.regs.pin_function_control = cdata;
            scp_pkg::OFF_CONVERTER: st_next.regs.converter_control    = cdata;
            default: ;
         endcase
      end

      // PLL output divider counts both input edges so an odd ratio still works
      // Field 10 toggles every third input edge: one output period
      // per three input periods at an even duty cycle
      // Limitation: pll_clock must stay well below mclk / 4
      div_last = div_sel;
      if (pclk_edge) begin
         if (st_reg.div_cnt >= div_last) begin
            st_next.div_cnt = 2'h0;
            st_next.div_out = ~st_reg.div_out;
         end else begin
            st_next.div_cnt = st_reg.div_cnt + 2'h1;
         end
      end

      // Pin output is registered; never driven while it serves as chip select
      // Registering keeps the pin free of glitches when the field changes
      st_next.pin_oe  = pin_drive & ~in_three_wire;
      st_next.pin_out = (pin_val ^ st_reg.regs.pin_function_control[scp_pkg::POL_BIT]) & st_next.pin_oe;
   end

   // Single state register; power-on reset loads all defaults
   // Asynchronous so defaults hold before the first clock arrives
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_reg                           <= '0;
         st_reg.tw                        <= scp_pkg::SCP_TW_IDLE;
         // Idle-high bus lines start high so release shows no false edge
         st_reg.scl                       <= '1;
         st_reg.sda                       <= '1;
         st_reg.cs                        <= '1;
         st_reg.regs.power_control_one    <= scp_pkg::POWER_ONE_RST;
         st_reg.regs.pin_function_control <= scp_pkg::PIN_FUNC_RST;
         st_reg.regs.converter_control    <= scp_pkg::CONVERTER_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Open-drain style acknowledge: only ever pulls low
   // The board pull-up supplies the high level of the data line
   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe  = st_reg.sda_oe;
   assign select_or_io_pin_out = st_reg.pin_out;
   assign select_or_io_pin_oe  = st_reg.pin_oe;

   // Control fields for the analogue and filter sections
   // Analogue sections stay off while the midrail field is 00
   assign regs                     = st_reg.regs;
   assign three_wire_mode          = st_reg.mode.s2;
   assign oversample_double        = st_reg.regs.converter_control[scp_pkg::OSR_BIT];
   assign midrail_impedance_select = st_reg.regs.power_control_one[scp_pkg::MID_LSB +: 2];
   assign analogue_enabled         = |st_reg.regs.power_control_one[scp_pkg::MID_LSB +: 2];
   assign amp_bias_enable          = st_reg.regs.power_control_one[scp_pkg::BIAS_BIT];
   assign pll_enable               = st_reg.regs.power_control_one[scp_pkg::PLLEN_BIT];

endmodule

`default_nettype wire

// ### scp_checker.sv
// Concurrent checks on the control port's top-level pins
`timescale 1ns/1ps
`default_nettype none
module scp_checker (
   input wire logic               mclk,
   input wire logic               nrst,
   input wire logic               serial_clock,
   input wire logic               temp_ok,
   input wire logic               serial_data_line_out,
   input wire logic               serial_data_line_oe,
   input wire logic               select_or_io_pin_out,
   input wire logic               select_or_io_pin_oe,
   input wire scp_pkg::scp_regs_t regs,
   input wire logic               three_wire_mode,
   input wire logic               oversample_double,
   input wire logic [1:0]         midrail_impedance_select,
   input wire logic               analogue_enabled,
   input wire logic               amp_bias_enable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Pin function field; outputs may lag a register write by one cycle
   wire logic [2:0] sel = regs.pin_function_control[2:0];

   a_ack_clk_low: assert property ($rose(serial_data_line_oe) |-> !serial_clock)
      else $error("ack started while serial clock high");
   a_ack_span: assert property ($rose(serial_data_line_oe) |-> serial_data_line_oe [*8])
      else $error("ack released before the pulse ended");
   a_ack_only_2w: assert property (serial_data_line_oe |-> !three_wire_mode && !serial_data_line_out)
      else $error("data line driven outside a 2-wire ack");
   a_pin_3w_input: assert property (three_wire_mode [*3] |-> !select_or_io_pin_oe)
      else $error("shared pin driven in 3-wire mode");
   a_pin_legal_sel: assert property (select_or_io_pin_oe |-> (sel inside {[3'h2:3'h5]}) ||
      ($past(sel) inside {[3'h2:3'h5]}))
      else $error("shared pin driven for chip select or reserved code");
   a_pin_temp_follow: assert property ((select_or_io_pin_oe && sel == 3'h2 && !regs.pin_function_control[3]
      && $stable(regs)) ##0 $rose(temp_ok) |-> ##[1:4] select_or_io_pin_out)
      else $error("pin does not follow temperature flag");
   a_midrail_map: assert property ($stable(regs) [*2] |-> midrail_impedance_select ==
      regs.power_control_one[1:0] && analogue_enabled == (|regs.power_control_one[1:0]))
      else $error("midrail outputs disagree with register");
   a_bias_osr_bits: assert property ($stable(regs) [*2] |-> amp_bias_enable == regs.power_control_one[3]
      && oversample_double == regs.converter_control[3])
      else $error("bias or oversample output disagrees with register");

   c_ack: cover property ($rose(serial_data_line_oe));
   c_commit_3w: cover property ($changed(regs) && three_wire_mode);
   c_pin_drive: cover property ($rose(select_or_io_pin_oe));
endmodule
`default_nettype wire

// ### scp_host_model.sv
// Host bus master model for 2-wire and 3-wire control writes
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
   input wire logic mclk,
   input wire logic sda_wire,
   output var logic scl,
   output var logic sda_low,
   output var logic cs_n
);
   localparam int H = 6; // Half period in mclk, margin over the four the port needs
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      cs_n = 1'b1;
   end
   // Lines change a fixed 2 ns after the clock edge
   task automatic hw(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   // One clock pulse: data set mid-low, wire sampled mid-high
   task automatic pulse(input logic b, output logic seen);
      scl = 1'b0;
      hw(H / 2);
      sda_low = !b;
      hw(H / 2);
      scl = 1'b1;
      hw(H / 2);
      seen = sda_wire;
      hw(H / 2);
   endtask
   // Start, up to nb bytes of {addr, word} each with an ack slot, stop
   task automatic tw_write(input logic [7:0] a, input logic [15:0] w, input int nb, output logic [2:0] ak);
      logic [23:0] s;
      logic        d;
      s = {a, w};
      ak = 3'h7;
      sda_low = 1'b1;
      hw(H);
      for (int k = 0; k < nb && k < 3; k++) begin
         for (int i = 23 - 8 * k; i > 15 - 8 * k; i--) pulse(s[i], d);
         pulse(1'b1, ak[2 - k]);
      end
      scl = 1'b0;
      hw(H / 2);
      sda_low = 1'b1;
      hw(H / 2);
      scl = 1'b1;
      hw(H);
      sda_low = 1'b0;
      hw(H);
   endtask
   // 3-wire frame; only the last 16 bits should be committed
   task automatic tw3(input logic [19:0] v);
      logic d;
      cs_n = 1'b0;
      hw(H);
      for (int i = 19; i >= 0; i--) pulse(v[i], d);
      cs_n = 1'b1;
      sda_low = 1'b0;
      hw(H);
   endtask
endmodule
`default_nettype wire

// ### scp_control_port_tb_top.sv
// Self-checking testbench of the serial control port
`timescale 1ns/1ps
`default_nettype none
module scp_control_port_tb_top;
   logic mclk, nrst, mode_pin, pll_clock, pll_lock, temp_ok, auto_mute_active;
   wire logic serial_clock, sda_low, cs_n, serial_data_line_in, serial_data_line_out, serial_data_line_oe;
   wire logic select_or_io_pin_in, select_or_io_pin_out, select_or_io_pin_oe, pll_enable;
   wire logic three_wire_mode, oversample_double, analogue_enabled, amp_bias_enable;
   wire logic [1:0] midrail_impedance_select;
   scp_pkg::scp_regs_t regs, mdl, prev;
   scp_pkg::scp_regs_t exp_q[$];
   int error_cnt, checks;
   logic [31:0] r;
   realtime t0;

   // Open-drain data line with pull-up; shared pin is chip select unless driven
   assign serial_data_line_in = !(sda_low || (serial_data_line_oe && !serial_data_line_out));
   assign select_or_io_pin_in = select_or_io_pin_oe ? select_or_io_pin_out : cs_n;

   scp_control_port dut (.mclk, .nrst, .mode_pin, .serial_clock, .serial_data_line_in, .serial_data_line_out,
      .serial_data_line_oe, .select_or_io_pin_in, .select_or_io_pin_out, .select_or_io_pin_oe, .pll_clock,
      .pll_lock, .temp_ok, .auto_mute_active, .regs, .three_wire_mode, .oversample_double,
      .midrail_impedance_select, .analogue_enabled, .amp_bias_enable, .pll_enable);
   scp_host_model host (.mclk(mclk), .sda_wire(serial_data_line_in), .scl(serial_clock), .sda_low(sda_low),
      .cs_n(cs_n));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // PLL clock of 800 ns period, phase unrelated to mclk
   initial begin
      pll_clock = 1'b0;
      #7;
      forever #400 pll_clock = ~pll_clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Any register change must match the oldest noted value, otherwise no change was allowed
   always @(posedge mclk) begin
      if (nrst && regs !== prev) check(regs, exp_q.size() > 0 ? exp_q.pop_front() : prev);
      prev = regs;
   end
   // Notes the register image a write should leave; unmapped addresses leave it alone
   task automatic expect_wr(input logic [6:0] a, input logic [8:0] d);
      scp_pkg::scp_regs_t m;
      m = mdl;
      case (a)
         scp_pkg::OFF_SOFT_RESET: m = {scp_pkg::POWER_ONE_RST, scp_pkg::PIN_FUNC_RST, scp_pkg::CONVERTER_RST};
         scp_pkg::OFF_POWER_ONE: m.power_control_one = d;
         scp_pkg::OFF_PIN_FUNC: m.pin_function_control = d;
         scp_pkg::OFF_CONVERTER: m.converter_control = d;
         default: ;
      endcase
      if (m !== mdl) exp_q.push_back(m);
      mdl = m;
   endtask
   task automatic w2(input logic [6:0] a, input logic [8:0] d);
      logic [2:0] ak;
      expect_wr(a, d);
      host.tw_write(8'h34, {a, d}, 3, ak);
      check(ak, 3'h0);
   endtask
   task automatic w3(input logic [6:0] a, input logic [8:0] d);
      expect_wr(a, d);
      r = $urandom;
      host.tw3({r[3:0], a, d});
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      final_report();
   end

   initial begin
      logic [2:0] ak;
      logic       e;
      {nrst, mode_pin, pll_lock, temp_ok, auto_mute_active} = 5'h00;
      r = $urandom(96917);
      repeat (6) @(posedge mclk);
      #2 nrst = 1'b1;
      mdl = {scp_pkg::POWER_ONE_RST, scp_pkg::PIN_FUNC_RST, scp_pkg::CONVERTER_RST};
      host.hw(8);
      check(regs, 27'h0000100);
      w2(7'h0E, 9'h108);
      check(oversample_double, 1'b1);
      r = $urandom;
      w2(7'h01, r[8:0]);
      check({analogue_enabled, midrail_impedance_select, amp_bias_enable, pll_enable},
         {|r[1:0], r[1:0], r[3], r[5]});
      $display("test 2-wire writes done");
      // Foreign address, read request, then a stop after the high byte: none may write
      r = $urandom;
      if (r[7:1] == 7'h1A) r[2] = ~r[2];
      host.tw_write({r[7:1], 1'b0}, 16'h1D08, 1, ak);
      check(ak[2], 1'b1);
      host.tw_write(8'h35, 16'h1D08, 1, ak);
      check(ak[2], 1'b1);
      host.tw_write(8'h34, 16'h1C00, 2, ak);
      check(ak[2:1], 2'h0);
      $display("test refused transfers done");
      for (int c = 0; c < 16; c++) begin
         r = $urandom;
         {temp_ok, auto_mute_active, pll_lock} = r[2:0];
         w2(7'h08, {5'h00, c[3], c[2:0]});
         e = c[2:0] == 3'h2 ? temp_ok : c[2:0] == 3'h3 ? auto_mute_active : pll_lock;
         check({select_or_io_pin_oe, (c[2:0] inside {3'h2, 3'h3, 3'h5}) ? select_or_io_pin_out : 1'b0},
            {c[2:0] inside {[3'h2:3'h5]}, (c[2:0] inside {3'h2, 3'h3, 3'h5}) ? e ^ c[3] : 1'b0});
      end
      for (int dv = 0; dv < 4; dv++) begin
         w2(7'h08, {3'h0, dv[1:0], 1'b0, 3'h4});
         @(posedge select_or_io_pin_out);
         @(posedge select_or_io_pin_out);
         t0 = $realtime;
         @(posedge select_or_io_pin_out);
         check(int'($realtime - t0), 800 * (dv + 1));
      end
      $display("test pin functions done");
      // Pin left at a steady high level so the mode change makes no chip-select edge
      temp_ok = 1'b0;
      w2(7'h08, 9'h002);
      temp_ok = 1'b1;
      host.hw(8);
      check(select_or_io_pin_out, 1'b1);
      mode_pin = 1'b1;
      host.hw(8);
      check({three_wire_mode, select_or_io_pin_oe}, 2'h2);
      r = $urandom;
      w3(7'h0E, r[8:0]);
      w3(7'h01, 9'h00B);
      w3(7'h20, 9'h1FF);
      w3(7'h00, r[17:9]);
      mode_pin = 1'b0;
      host.hw(8);
      w2(7'h0E, 9'h0A8);
      host.hw(8);
      check(exp_q.size(), 0);
      $display("test 3-wire writes done");
      final_report();
   end
endmodule
bind scp_control_port scp_checker chk (.mclk(mclk), .nrst(nrst), .serial_clock(serial_clock), .temp_ok(temp_ok),
   .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
   .select_or_io_pin_out(select_or_io_pin_out), .select_or_io_pin_oe(select_or_io_pin_oe), .regs(regs),
   .three_wire_mode(three_wire_mode), .oversample_double(oversample_double),
   .midrail_impedance_select(midrail_impedance_select), .analogue_enabled(analogue_enabled),
   .amp_bias_enable(amp_bias_enable));
`default_nettype wire
